/* File: hw/dma_read_status_irq_flags.sv */
/*
 * Status flags, interrupt flags and interrupt output of the memory-to-stream
 * channel, with a small control register and a captured descriptor pointer.
 * Assumes the engine reports descriptor fetches, completions, delay timeouts,
 * other errors and its idle state as one-cycle pulses or levels on core_clk.
 */
`timescale 1ns/1ps

module dma_read_status_irq_flags
    import dma_stat_pkg::*;
#(
    parameter bit                 SG_MODE    = 1'b1,
    parameter int                 PTR_W      = 32,
    parameter logic [PTR_W-1:0]   DESC_BASE  = '0,
    parameter logic [PTR_W-1:0]   DESC_LIMIT = '1
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              desc_check,
    input  wire logic [PTR_W-1:0]  cur_ptr_in,
    input  wire logic [PTR_W-1:0]  nxt_ptr_in,
    input  wire logic              desc_eof_done,
    input  wire logic              xfer_done,
    input  wire logic              delay_timeout,
    input  wire logic              other_error,
    input  wire logic              engine_idle,
    output logic                   run_stop_control,
    output logic                   engine_halted_status,
    output logic      [PTR_W-1:0]  current_descriptor_pointer,
    output logic                   irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic              run_stop_ff;
    logic              halted_ff;
    logic              cmp_en_ff;
    logic              dly_en_ff;
    logic              err_en_ff;
    logic [THR_W-1:0]  thr_ff;
    logic [THR_W-1:0]  cmp_cnt_ff;
    logic              dec_err_ff;
    logic              cmp_flag_ff;
    logic              dly_flag_ff;
    logic              err_flag_ff;
    logic [PTR_W-1:0]  cur_ptr_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              irq_ff;

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    // The valid descriptor window is inclusive at both ends.
    function automatic logic ptr_bad(input logic [PTR_W-1:0] p);
        ptr_bad = (p < DESC_BASE) || (p > DESC_LIMIT);
    endfunction : ptr_bad

    wire logic wr_ctrl   = reg_wr && (reg_addr == CTRL_OFFSET);
    wire logic wr_status = reg_wr && (reg_addr == STATUS_OFFSET);
    wire logic wr_cur    = reg_wr && (reg_addr == CURDESC_OFFSET);

    // Decode check only makes sense while descriptors are fetched.
    wire logic cur_bad   = SG_MODE && desc_check && ptr_bad(cur_ptr_in);
    wire logic nxt_bad   = SG_MODE && desc_check && ptr_bad(nxt_ptr_in);
    wire logic dec_evt   = cur_bad || nxt_bad;
    wire logic err_evt   = dec_evt || other_error;

    wire logic cmp_evt   = SG_MODE ? desc_eof_done : xfer_done;
    wire logic dly_evt   = SG_MODE && delay_timeout;

    wire logic clr_cmp   = wr_status && reg_wdata[CMP_FLAG_BIT];
    wire logic clr_dly   = wr_status && reg_wdata[DLY_FLAG_BIT];
    wire logic clr_err   = wr_status && reg_wdata[ERR_FLAG_BIT];

    // Set wins over clear so an event in the clearing cycle is kept.
    wire logic nxt_cmp_flag = cmp_evt || (cmp_flag_ff && !clr_cmp);
    wire logic nxt_dly_flag = dly_evt || (dly_flag_ff && !clr_dly);
    wire logic nxt_err_flag = err_evt || (err_flag_ff && !clr_err);

    // Completions are counted up to all ones, where the count holds; the count
    // restarts when software acknowledges the completion flag.
    wire logic [THR_W-1:0] cnt_inc = cmp_evt && (cmp_cnt_ff != '1) ?
                                     cmp_cnt_ff + 1'b1 : cmp_cnt_ff;
    wire logic [THR_W-1:0] nxt_cmp_cnt = clr_cmp ? {{(THR_W-1){1'b0}}, cmp_evt}
                                                 : cnt_inc;
    wire logic thr_met_nxt = !SG_MODE || (nxt_cmp_cnt >= thr_ff);

    // Built from next-state values so irq rises in the same edge as its flag.
    wire logic nxt_irq = (nxt_cmp_flag && cmp_en_ff && thr_met_nxt) ||
                         (nxt_dly_flag && dly_en_ff) ||
                         (nxt_err_flag && err_en_ff);

    // Halted waits for the engine to report idle, so software never sees a
    // halted channel while a transfer is still draining.
    wire logic nxt_run_stop = dec_evt ? 1'b0 :
                              wr_ctrl ? reg_wdata[RUN_STOP_BIT] : run_stop_ff;
    wire logic nxt_halted   = nxt_run_stop ? 1'b0 :
                              (halted_ff || engine_idle);

    // The engine owns the pointer; software may move it only while the
    // channel is stopped and halted, and an error capture always wins.
    wire logic [PTR_W-1:0] nxt_cur_ptr =
        cur_bad ? cur_ptr_in :
        nxt_bad ? nxt_ptr_in :
        (wr_cur && halted_ff && !run_stop_ff) ? reg_wdata[PTR_W-1:0] :
        cur_ptr_ff;

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_word;

    always_comb begin
        ctrl_word                                = WORD_ZERO;
        ctrl_word[RUN_STOP_BIT]                  = run_stop_ff;
        ctrl_word[CMP_EN_BIT]                    = cmp_en_ff;
        ctrl_word[DLY_EN_BIT]                    = dly_en_ff;
        ctrl_word[ERR_EN_BIT]                    = err_en_ff;
        ctrl_word[THR_LSB +: THR_W]              = thr_ff;
        status_word                              = WORD_ZERO;
        status_word[HALTED_BIT]                  = halted_ff;
        status_word[DEC_ERR_BIT]                 = dec_err_ff;
        status_word[CMP_FLAG_BIT]                = cmp_flag_ff;
        status_word[DLY_FLAG_BIT]                = dly_flag_ff;
        status_word[ERR_FLAG_BIT]                = err_flag_ff;
        status_word[THR_LSB +: THR_W]            = SG_MODE ? thr_ff : '0;
        rd_word                                  = WORD_ZERO;
        if (reg_addr == CTRL_OFFSET) begin
            rd_word = ctrl_word;
        end else if (reg_addr == STATUS_OFFSET) begin
            rd_word = status_word;
        end else if (reg_addr == CURDESC_OFFSET) begin
            rd_word[PTR_W-1:0] = cur_ptr_ff;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_stop_ff <= 1'b0;
            halted_ff   <= 1'b1;
            cmp_en_ff   <= 1'b0;
            dly_en_ff   <= 1'b0;
            err_en_ff   <= 1'b0;
            thr_ff      <= THR_RESET;
        end else if (clk_en) begin
            run_stop_ff <= nxt_run_stop;
            halted_ff   <= nxt_halted;
            if (wr_ctrl) begin
                cmp_en_ff <= reg_wdata[CMP_EN_BIT];
                dly_en_ff <= reg_wdata[DLY_EN_BIT];
                err_en_ff <= reg_wdata[ERR_EN_BIT];
                // A zero threshold would never gate; keep at least one.
                thr_ff    <= (reg_wdata[THR_LSB +: THR_W] == '0) ? THR_RESET
                                                                 : reg_wdata[THR_LSB +: THR_W];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dec_err_ff  <= 1'b0;
            cmp_flag_ff <= 1'b0;
            dly_flag_ff <= 1'b0;
            err_flag_ff <= 1'b0;
            cmp_cnt_ff  <= '0;
            irq_ff      <= 1'b0;
        end else if (clk_en) begin
            // The decode error is sticky until the next reset of the channel.
            dec_err_ff  <= dec_err_ff || dec_evt;
            cmp_flag_ff <= nxt_cmp_flag;
            dly_flag_ff <= nxt_dly_flag;
            err_flag_ff <= nxt_err_flag;
            cmp_cnt_ff  <= nxt_cmp_cnt;
            irq_ff      <= nxt_irq;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ptr_ff <= '0;
            rdata_ff   <= WORD_ZERO;
        end else if (clk_en) begin
            cur_ptr_ff <= nxt_cur_ptr;
            // Read data stands only in the cycle after the strobe.
            rdata_ff   <= reg_rd ? rd_word : WORD_ZERO;
        end
    end

    assign reg_rdata                  = rdata_ff;
    assign run_stop_control           = run_stop_ff;
    assign engine_halted_status       = halted_ff;
    assign current_descriptor_pointer = cur_ptr_ff;
    assign irq                        = irq_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    dec_err_set_a: assert property (clk_en && dec_evt |=> dec_err_ff)
        else $error("decode error flag not set");
    stop_on_dec_a: assert property (clk_en && dec_evt |=> !run_stop_ff)
        else $error("run/stop not cleared on decode error");
    halt_wait_a: assert property (clk_en && $rose(halted_ff) |-> $past(engine_idle))
        else $error("halted rose before engine idle");
    direct_zero_a: assert property (!SG_MODE |-> !dec_err_ff && !dly_flag_ff)
        else $error("scatter-gather flag set in direct mode");
    rsvd_zero_a: assert property (reg_rdata[RSVD_A_BIT] == 1'b0 &&
                                  reg_rdata[RSVD_B_BIT] == 1'b0)
        else $error("reserved bit read nonzero");
    cmp_set_a: assert property (clk_en && cmp_evt |=> cmp_flag_ff)
        else $error("completion flag missed");
    dly_set_a: assert property (clk_en && dly_evt |=> dly_flag_ff)
        else $error("delay flag missed");
    err_set_a: assert property (clk_en && err_evt |=> err_flag_ff)
        else $error("error flag missed");
    w1c_clear_a: assert property (clk_en && clr_err && !err_evt |=> !err_flag_ff)
        else $error("error flag not cleared by one");
    w0_keep_a: assert property (clk_en && wr_status && !reg_wdata[CMP_FLAG_BIT] &&
                                cmp_flag_ff |=> cmp_flag_ff)
        else $error("completion flag lost on zero write");
    cmp_gate_a: assert property (clk_en && !cmp_en_ff && !dly_flag_ff && !err_flag_ff
                                 && !dly_evt && !err_evt |=> !irq_ff)
        else $error("interrupt without enabled source");
    dly_irq_a: assert property (clk_en && dly_flag_ff && dly_en_ff && !clr_dly
                                |=> irq_ff)
        else $error("delay interrupt not raised");
    thr_show_a: assert property (SG_MODE && reg_rd && reg_addr == STATUS_OFFSET &&
                                 clk_en && !wr_ctrl |=> reg_rdata[THR_LSB +: THR_W] == thr_ff)
        else $error("threshold field wrong");
    ptr_cap_a: assert property (clk_en && cur_bad |=> cur_ptr_ff == $past(cur_ptr_in))
        else $error("faulting pointer not captured");

    // ------------------------------------------------------------------
    // Clearing, keeping and interrupt gating
    // ------------------------------------------------------------------
    cmp_clear_a: assert property (clk_en && clr_cmp && !cmp_evt
                                  |=> !cmp_flag_ff)
        else $error("completion flag not cleared by one");
    dly_clear_a: assert property (clk_en && clr_dly && !dly_evt
                                  |=> !dly_flag_ff)
        else $error("delay flag not cleared by one");
    w0_dly_a: assert property (clk_en && wr_status && !reg_wdata[DLY_FLAG_BIT] &&
                               dly_flag_ff |=> dly_flag_ff)
        else $error("delay flag lost on zero write");
    w0_err_a: assert property (clk_en && wr_status && !reg_wdata[ERR_FLAG_BIT] &&
                               err_flag_ff |=> err_flag_ff)
        else $error("error flag lost on zero write");
    err_irq_a: assert property (clk_en && err_evt && err_en_ff |=> irq_ff)
        else $error("error interrupt not raised");
    cmp_irq_a: assert property (clk_en && cmp_flag_ff && cmp_en_ff && !clr_cmp &&
                                cmp_cnt_ff >= thr_ff |=> irq_ff)
        else $error("completion interrupt not raised at threshold");
    thr_hold_a: assert property (SG_MODE && clk_en && !dly_en_ff && !err_en_ff &&
                                 !cmp_evt && !clr_cmp && cmp_cnt_ff < thr_ff |=> !irq_ff)
        else $error("completion interrupt below threshold");
    no_enable_a: assert property (clk_en && !cmp_en_ff && !dly_en_ff && !err_en_ff
                                  |=> !irq_ff)
        else $error("interrupt with every source disabled");

    // ------------------------------------------------------------------
    // Halting, pointer capture and clock enable
    // ------------------------------------------------------------------
    run_halt_a: assert property (run_stop_ff |-> !halted_ff)
        else $error("halted while running");
    dec_keep_a: assert property (dec_err_ff |=> dec_err_ff)
        else $error("decode error flag dropped");
    nxt_cap_a: assert property (clk_en && nxt_bad && !cur_bad
                                |=> cur_ptr_ff == $past(nxt_ptr_in))
        else $error("faulting next pointer not captured");
    ptr_lock_a: assert property (clk_en && !cur_bad && !nxt_bad &&
                                 !(wr_cur && halted_ff && !run_stop_ff) |=> $stable(cur_ptr_ff))
        else $error("pointer moved without error or legal write");
    thr_floor_a: assert property (thr_ff != '0)
        else $error("threshold reads zero");
    // Freezing is checked on the three flags, irq_ff and the read data only.
    freeze_hold_a: assert property (!clk_en |=> $stable(cmp_flag_ff) &&
                                    $stable(dly_flag_ff) && $stable(err_flag_ff) &&
                                    $stable(irq_ff) && $stable(reg_rdata))
        else $error("state changed with clock enable low");
    rdata_idle_a: assert property (clk_en && !reg_rd |=> reg_rdata == WORD_ZERO)
        else $error("read data outside its cycle");

endmodule : dma_read_status_irq_flags

/* File: hw/dma_stat_pkg.sv */
/*
 * Constants shared by the read channel status and interrupt flag logic.
 * Assumes a 32-bit register port with byte addresses on an 8-bit address.
 */
package dma_stat_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET = 8'h04;
    localparam logic [7:0]  CURDESC_OFFSET = 8'h08;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int RUN_STOP_BIT   = 0;
    localparam int CMP_EN_BIT     = 12;
    localparam int DLY_EN_BIT     = 13;
    localparam int ERR_EN_BIT     = 14;
    localparam int THR_LSB        = 16;
    localparam int THR_W          = 8;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int HALTED_BIT     = 0;
    localparam int DEC_ERR_BIT    = 10;
    localparam int RSVD_A_BIT     = 11;
    localparam int CMP_FLAG_BIT   = 12;
    localparam int DLY_FLAG_BIT   = 13;
    localparam int ERR_FLAG_BIT   = 14;
    localparam int RSVD_B_BIT     = 15;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  THR_RESET     = 8'h01;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

endpackage : dma_stat_pkg

/* File: dv/testbench.sv */
/*
 * Self-checking bench for the read channel status and interrupt flag block.
 * Assumes dma_stat_pkg and the design module are compiled first; one core_clk domain.
 */
`timescale 1ns/1ps
module testbench;
    import dma_stat_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam logic [31:0] BASE  = 32'h0000_1000;
    localparam logic [31:0] LIMIT = 32'h0000_ffff;
    logic              core_clk    = 1'b0;
    logic              rst_b       = 1'b0;
    logic [ADDR_W-1:0] reg_addr    = '0;
    logic [DATA_W-1:0] reg_wdata   = '0;
    logic              reg_wr      = 1'b0;
    logic              reg_rd      = 1'b0;
    logic [4:0]        evt         = 5'h00;
    logic [31:0]       cur_ptr     = BASE;
    logic [31:0]       nxt_ptr     = BASE;
    logic              engine_idle = 1'b0;
    logic              clk_en      = 1'b1;
    logic [DATA_W-1:0] reg_rdata, rdata_dir, rd_dir;
    logic              run_stop, halted, irq, irq_dir;
    logic [31:0]       cur_desc;
    int                failures    = 0;
    int                checks_done = 0;
    int                thr;

    // Bits of evt: descriptor check, end-of-frame done, transfer done, delay, other error.
    dma_read_status_irq_flags #(.SG_MODE(1'b1), .PTR_W(32), .DESC_BASE(BASE),
        .DESC_LIMIT(LIMIT)) dma_read_status_irq_flags_i (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .desc_check(evt[4]), .cur_ptr_in(cur_ptr), .nxt_ptr_in(nxt_ptr),
        .desc_eof_done(evt[3]), .xfer_done(evt[2]), .delay_timeout(evt[1]),
        .other_error(evt[0]), .engine_idle(engine_idle), .run_stop_control(run_stop),
        .engine_halted_status(halted), .current_descriptor_pointer(cur_desc), .irq(irq));

    // The direct register mode copy shares every input so both modes see one stimulus.
    dma_read_status_irq_flags #(.SG_MODE(1'b0), .PTR_W(32), .DESC_BASE(BASE),
        .DESC_LIMIT(LIMIT)) dma_read_status_irq_flags_dir_i (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_dir),
        .desc_check(evt[4]), .cur_ptr_in(cur_ptr), .nxt_ptr_in(nxt_ptr),
        .desc_eof_done(evt[3]), .xfer_done(evt[2]), .delay_timeout(evt[1]),
        .other_error(evt[0]), .engine_idle(engine_idle), .run_stop_control(),
        .engine_halted_status(), .current_descriptor_pointer(), .irq(irq_dir));

    always #25 core_clk = ~core_clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so both copies are sampled there.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        rd_dir = rdata_dir;
        chk(reg_rdata, e);
    endtask : rd

    task automatic ev(input logic [4:0] m);
        @(posedge core_clk);
        evt <= m;
        @(posedge core_clk);
        evt <= 5'h00;
        #1;
    endtask : ev

    function automatic logic [31:0] sts(input logic h, input logic dec, input logic cmp,
                                        input logic dly, input logic err, input logic [7:0] t);
        logic [31:0] v;
        v               = WORD_ZERO;
        v[HALTED_BIT]   = h;
        v[DEC_ERR_BIT]  = dec;
        v[CMP_FLAG_BIT] = cmp;
        v[DLY_FLAG_BIT] = dly;
        v[ERR_FLAG_BIT] = err;
        v[THR_LSB +: THR_W] = t;
        return v;
    endfunction : sts

    function automatic logic [31:0] ctl(input logic rs, input logic c, input logic d,
                                        input logic e, input logic [7:0] t);
        logic [31:0] v;
        v               = WORD_ZERO;
        v[RUN_STOP_BIT] = rs;
        v[CMP_EN_BIT]   = c;
        v[DLY_EN_BIT]   = d;
        v[ERR_EN_BIT]   = e;
        v[THR_LSB +: THR_W] = t;
        return v;
    endfunction : ctl

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        #2_000_000;
        chk(32'h0, 32'h1);
        wrap_up();
    end

    initial begin
        void'($urandom(27705));
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(CTRL_OFFSET, ctl(1'b0, 1'b0, 1'b0, 1'b0, THR_RESET));
        rd(STATUS_OFFSET, sts(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, THR_RESET));
        rd(8'h0c, WORD_ZERO);
        wr(STATUS_OFFSET, 32'h0000_8800);
        rd(STATUS_OFFSET, sts(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, THR_RESET));
        ev(5'h06);
        rd(STATUS_OFFSET, sts(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, THR_RESET));
        chk(rd_dir, sts(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00));
        chk({31'h0, irq_dir}, 32'h0);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(STATUS_OFFSET, sts(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, THR_RESET));
        wr(CTRL_OFFSET, ctl(1'b1, 1'b0, 1'b1, 1'b0, THR_RESET));
        chk({31'h0, halted}, 32'h0);
        ev(5'h02);
        chk({31'h0, irq}, 32'h1);
        wr(STATUS_OFFSET, WORD_ZERO);
        rd(STATUS_OFFSET, sts(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, THR_RESET));
        chk({31'h0, irq}, 32'h1);
        wr(STATUS_OFFSET, 32'h0000_2000);
        rd(STATUS_OFFSET, sts(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, THR_RESET));
        chk({31'h0, irq}, 32'h0);
        clk_en <= 1'b0;
        ev(5'h02);
        clk_en <= 1'b1;
        rd(STATUS_OFFSET, sts(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, THR_RESET));
        chk({31'h0, irq}, 32'h0);
        thr = 1 + $urandom_range(3);
        wr(CTRL_OFFSET, ctl(1'b1, 1'b1, 1'b0, 1'b0, thr[7:0]));
        for (int i = 1; i < thr; i++) begin
            ev(5'h08);
            chk({31'h0, irq}, 32'h0);
        end
        ev(5'h08);
        chk({31'h0, irq}, 32'h1);
        rd(STATUS_OFFSET, sts(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, thr[7:0]));
        wr(STATUS_OFFSET, 32'h0000_1000);
        #1;
        chk({31'h0, irq}, 32'h0);
        wr(CTRL_OFFSET, ctl(1'b1, 1'b0, 1'b0, 1'b1, THR_RESET));
        ev(5'h01);
        chk({31'h0, irq}, 32'h1);
        wr(STATUS_OFFSET, 32'h0000_4000);
        #1;
        chk({31'h0, irq}, 32'h0);
        cur_ptr <= BASE + ($urandom % 32'h0000_f000);
        nxt_ptr <= LIMIT;
        ev(5'h10);
        rd(STATUS_OFFSET, sts(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, THR_RESET));
        nxt_ptr <= 32'h0000_0100;
        ev(5'h10);
        chk({31'h0, run_stop}, 32'h0);
        chk(cur_desc, 32'h0000_0100);
        chk({31'h0, halted}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rd(STATUS_OFFSET, sts(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, THR_RESET));
        chk({31'h0, rd_dir[DEC_ERR_BIT]}, 32'h0);
        engine_idle <= 1'b1;
        for (int n = 0; n < 20 && halted !== 1'b1; n++) @(posedge core_clk);
        #1;
        chk({31'h0, halted}, 32'h1);
        if (halted === 1'b1) begin
            wr(CURDESC_OFFSET, BASE);
            rd(CURDESC_OFFSET, BASE);
        end
        wrap_up();
    end
endmodule : testbench
